/* logic/dancer_pkg.sv */
// Purpose: shared constants and types for the dancer speed trim block
// Assumes: 50 MHz control clock, 32-bit APB register bus
// Notes: percentages are in 0.1% steps (0..1000)
package dancer_pkg;
   localparam int unsigned clk_hz = 50000000;
   // 100 us keeps the loop responsive; a slower period would stretch every settling test
   localparam int unsigned sample_us = 100;
   localparam int unsigned sample_cycles = clk_hz / 1000000 * sample_us;
   // register byte offsets
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] set_point_off = 8'h04;
   localparam logic [7:0] diff_time_off = 8'h08;
   localparam logic [7:0] upper_limit_off = 8'h0c;
   localparam logic [7:0] lower_limit_off = 8'h10;
   localparam logic [7:0] out_sel_off = 8'h14;
   localparam logic [7:0] in_sel_off = 8'h18;
   localparam logic [7:0] main_speed_off = 8'h1c;
   localparam logic [7:0] accel_off = 8'h20;
   localparam logic [7:0] status_off = 8'h24;
   localparam logic [7:0] cmd_off = 8'h28;
   localparam logic [7:0] pid_out_off = 8'h2c;
   // codes
   localparam logic [15:0] no_function = 16'h270f;   // 9999
   localparam logic [7:0] act_first = 8'h28;          // 40
   localparam logic [7:0] act_last = 8'h2b;           // 43
   localparam logic [7:0] in_pid_select = 8'h0e;      // 14
   localparam logic [7:0] out_upper = 8'h0f;          // 15
   localparam logic [7:0] out_lower = 8'h0e;          // 14
   localparam logic [7:0] out_pid = 8'h2f;            // 47
   localparam logic [7:0] neg_logic_base = 8'h64;     // 100
   localparam logic [15:0] pct_half = 16'h01f4;       // 50.0%
   localparam logic [15:0] pct_full = 16'h03e8;       // 100.0%
   localparam logic [15:0] diff_min = 16'h0001;       // 0.01 s
   localparam logic [15:0] diff_max = 16'h03e8;       // 10.00 s
   localparam logic [15:0] raw_4ma = 16'h0333;        // 4 mA of 20 mA full scale (12-bit adc)
   localparam logic [15:0] raw_full = 16'h0fff;
   localparam logic [15:0] raw_5v = 16'h07ff;         // 5 V of 10 V full scale
   localparam int unsigned n_terms = 3;
   typedef enum logic [1:0] {range_4_20ma, range_0_5v, range_0_10v} range_t;
endpackage : dancer_pkg

/* logic/ramp_if.sv */
`timescale 1ns/1ns
// Purpose: carries the main speed ramp request and result
// Assumes: single clock domain
// Notes: none
interface ramp_if;
   logic [15:0] target;
   logic [15:0] accel_step;
   logic [15:0] decel_step;
   logic tick;
   logic [15:0] speed;
   modport ctrl (output target, output accel_step, output decel_step, output tick, input speed);
   modport ramp (input target, input accel_step, input decel_step, input tick, output speed);
endinterface : ramp_if

/* logic/speed_ramp.sv */
`timescale 1ns/1ns
// Purpose: ramps the main speed command toward its target
// Assumes: steps are per sample tick, taken from the second accel/decel times
// Notes: zero step jumps straight to the target
module speed_ramp (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   ramp_if.ramp rp
);
   import dancer_pkg::*;
   typedef struct packed {
      logic [15:0] speed;
   } ramp_state_t;
   ramp_state_t st_ff;
   ramp_state_t nxt_st;
   logic [16:0] up;
   logic [16:0] dn;
   always_comb begin
      nxt_st = st_ff;
      up = {1'b0, st_ff.speed} + {1'b0, rp.accel_step};
      dn = {1'b0, st_ff.speed} - {1'b0, rp.decel_step};
      if (rp.tick) begin
         if (rp.target > st_ff.speed) begin
            if (rp.accel_step == 16'h0000 || up[16] || up[15:0] > rp.target) begin
               nxt_st.speed = rp.target;
            end else begin
               nxt_st.speed = up[15:0];
            end
         end else if (rp.target < st_ff.speed) begin
            if (rp.decel_step == 16'h0000 || dn[16] || dn[15:0] < rp.target) begin
               nxt_st.speed = rp.target;
            end else begin
               nxt_st.speed = dn[15:0];
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end
   assign rp.speed = st_ff.speed;
endmodule : speed_ramp

/* logic/dancer_pid_speed_trim.sv */
`timescale 1ns/1ns
// Purpose: dancer roller pid trim added to the ramped main speed
// Assumes: feedback is a 12-bit adc sample, speeds in 0.01 Hz, APB slave
// Notes: proportional gain is fixed at unity here; no integral term is computed
// How it works
// [R1] dancer active only for action 40..43
// [R2] pid on roller position added to speed
// [R3] set point 0..100%, 9999 means 50%
// [R4] derivative time 0.01..10 s, off disables
// [R5] tuning registers writable any time
// [R6] feedback scaled per input range select
// [R7] input code 14 maps pid select input
// [R8] unassigned select leaves action alone deciding
// [R9] action 0 or select low: normal run
// [R10] feedback terminal never a main source
// [R11] upper flag above limit, code 15/115
// [R12] lower flag below limit, code 14/114
// [R13] pid active output on code 47/147
// [R14] forward flag only on forward rotation
// [R15] codes 100 up give negative logic
// [R16] main speed ramps with second times
// [R17] 42/43 ratio add, odd forward action
// [R18] 0..100% spans bias..gain frequency
// [R19] evaluate once per sample period
module dancer_pid_speed_trim (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [6:0] input_terms,
   input wire logic [11:0] feedback_raw,
   input wire logic [15:0] main_speed_in,
   input wire logic main_from_feedback,
   input wire logic rot_forward,
   input wire logic rot_reverse,
   output logic [15:0] speed_cmd,
   output logic [dancer_pkg::n_terms-1:0] output_terms,
   output logic output_common
);
   import dancer_pkg::*;
   typedef struct packed {
      logic [7:0] action;
      logic [15:0] set_point;
      logic [15:0] diff_time;
      logic diff_en;
      logic [15:0] upper;
      logic [15:0] lower;
      logic [23:0] out_sel;
      logic [55:0] in_sel;
      logic [1:0] range;
      logic [15:0] bias_hz;
      logic [15:0] gain_hz;
      logic [15:0] accel_step;
      logic [15:0] decel_step;
      logic [15:0] main_hold;
      logic [31:0] sample_cnt;
      logic tick;
      logic signed [17:0] prev_dev;
      logic signed [17:0] pid_out;
      logic [15:0] meas;
      logic up_flag;
      logic dn_flag;
      logic act_flag;
      logic fwd_flag;
      logic [n_terms-1:0] terms;
      logic [15:0] cmd;
      logic [31:0] rdata;
   } top_state_t;
   top_state_t st_ff;
   top_state_t nxt_st;
   ramp_if rif ();
   speed_ramp speed_ramp_i (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .rp(rif.ramp)
   );
   logic wr;
   logic rd;
   logic sel_assigned;
   logic sel_level;
   logic active;
   logic [15:0] sp_eff;
   logic [31:0] scaled;
   logic signed [17:0] dev;
   logic signed [35:0] dterm;
   logic signed [17:0] pid_raw;
   logic signed [33:0] trim;
   logic signed [17:0] sum;
   logic [7:0] code;
   logic fn;
   ////////////////////////////////////////////////////////////////////////////
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   always_comb begin
      nxt_st = st_ff;
      sel_assigned = 1'b0;
      sel_level = 1'b0;
      for (int i = 0; i < 7; i++) begin
         if (st_ff.in_sel[i*8 +: 8] == in_pid_select) begin // [R7]
            sel_assigned = 1'b1;
            sel_level = sel_level | input_terms[i];
         end
      end
      // [R1] [R8] [R9]
      active = (st_ff.action >= act_first) && (st_ff.action <= act_last) && (!sel_assigned || sel_level);
      sp_eff = (st_ff.set_point == no_function) ? pct_half : st_ff.set_point; // [R3]
      case (range_t'(st_ff.range)) // [R6]
         range_4_20ma: begin
            if ({4'h0, feedback_raw} <= raw_4ma) begin
               scaled = 32'h0;
            end else begin
               scaled = ({16'h0, ({4'h0, feedback_raw} - raw_4ma)} * 32'd1000) / {16'h0, raw_full - raw_4ma};
            end
         end
         range_0_5v: begin
            if ({4'h0, feedback_raw} >= raw_5v) begin
               scaled = {16'h0, pct_full};
            end else begin
               scaled = ({20'h0, feedback_raw} * 32'd1000) / {16'h0, raw_5v};
            end
         end
         range_0_10v: scaled = ({20'h0, feedback_raw} * 32'd1000) / {16'h0, raw_full};
         default: scaled = 32'h0;
      endcase
      // [R17] even codes reverse action: deviation is set point minus measured
      dev = st_ff.action[0] ? ($signed({2'b00, st_ff.meas}) - $signed({2'b00, sp_eff}))
                            : ($signed({2'b00, sp_eff}) - $signed({2'b00, st_ff.meas}));
      // [R4] longer derivative time scales the deviation change up
      dterm = st_ff.diff_en ? ((dev - st_ff.prev_dev) * $signed({2'b00, st_ff.diff_time})) : 36'sd0;
      pid_raw = dev + 18'(dterm >>> 4);
      if (pid_raw > $signed({2'b00, pct_full})) begin
         pid_raw = $signed({2'b00, pct_full});
      end else if (pid_raw < -$signed({2'b00, pct_full})) begin
         pid_raw = -$signed({2'b00, pct_full});
      end
      // [R18] percent maps onto bias..gain frequency span
      trim = (st_ff.pid_out * $signed({2'b00, st_ff.gain_hz - st_ff.bias_hz})) / 34'sd1000;
      if (st_ff.action[1]) begin // [R17] ratio of main speed
         trim = (trim * $signed({18'h0, rif.speed})) / $signed({18'h0, (st_ff.gain_hz == 16'h0) ? 16'h1 : st_ff.gain_hz});
      end
      sum = $signed({2'b00, rif.speed}) + 18'(trim); // [R2]
      nxt_st.tick = 1'b0;
      if (st_ff.sample_cnt >= 32'(sample_cycles - 1)) begin // [R19]
         nxt_st.sample_cnt = 32'h0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.sample_cnt = st_ff.sample_cnt + 32'h1;
      end
      // [R10] main source from the feedback terminal is refused, last good value held
      if (!main_from_feedback) begin
         nxt_st.main_hold = main_speed_in;
      end
      if (st_ff.tick) begin // [R19]
         nxt_st.meas = scaled[15:0];
         if (active) begin
            nxt_st.pid_out = pid_raw;
            nxt_st.prev_dev = dev;
         end else begin
            nxt_st.pid_out = 18'sd0;
            nxt_st.prev_dev = 18'sd0;
         end
         // upper and lower flags compare the measurement held from the previous tick: one sample of lag
         nxt_st.act_flag = active; // [R13]
         nxt_st.up_flag = active && st_ff.upper != no_function && st_ff.meas > st_ff.upper; // [R11]
         nxt_st.dn_flag = active && st_ff.lower != no_function && st_ff.meas < st_ff.lower; // [R12]
         nxt_st.fwd_flag = rot_forward && !rot_reverse; // [R14]
         nxt_st.cmd = !active ? rif.speed : (sum < 18'sd0 ? 16'h0 : (sum[16] ? 16'hffff : sum[15:0])); // [R9]
      end
      for (int t = 0; t < n_terms; t++) begin
         code = st_ff.out_sel[t*8 +: 8];
         if (code >= neg_logic_base) begin
            code = code - neg_logic_base;
         end
         case (code)
            out_upper: fn = st_ff.up_flag;
            out_lower: fn = st_ff.dn_flag;
            out_pid: fn = st_ff.act_flag;
            default: fn = st_ff.fwd_flag;
         endcase
         nxt_st.terms[t] = fn ^ (st_ff.out_sel[t*8 +: 8] >= neg_logic_base); // [R15]
      end
      // [R5] writes accepted regardless of run state or mode
      if (wr) begin
         case (paddr)
            ctrl_off: begin
               nxt_st.action = pwdata[7:0];
               nxt_st.range = pwdata[9:8];
            end
            set_point_off: begin
               if (pwdata[15:0] <= pct_full || pwdata[15:0] == no_function) begin
                  nxt_st.set_point = pwdata[15:0];
               end
            end
            diff_time_off: begin
               nxt_st.diff_en = pwdata[16];
               if (pwdata[15:0] >= diff_min && pwdata[15:0] <= diff_max) begin
                  nxt_st.diff_time = pwdata[15:0];
               end
            end
            upper_limit_off: nxt_st.upper = pwdata[15:0];
            lower_limit_off: nxt_st.lower = pwdata[15:0];
            out_sel_off: nxt_st.out_sel = pwdata[23:0];
            in_sel_off: nxt_st.in_sel = {st_ff.in_sel[55:32], pwdata};
            main_speed_off: begin
               nxt_st.bias_hz = pwdata[15:0];
               nxt_st.gain_hz = pwdata[31:16];
            end
            accel_off: begin
               nxt_st.accel_step = pwdata[15:0];
               nxt_st.decel_step = pwdata[31:16];
            end
            status_off: nxt_st.in_sel = {pwdata[23:0], st_ff.in_sel[31:0]};
            default: nxt_st.action = st_ff.action;
         endcase
      end
      if (rd) begin
         case (paddr)
            ctrl_off: nxt_st.rdata = {22'h0, st_ff.range, st_ff.action};
            set_point_off: nxt_st.rdata = {16'h0, st_ff.set_point};
            diff_time_off: nxt_st.rdata = {15'h0, st_ff.diff_en, st_ff.diff_time};
            upper_limit_off: nxt_st.rdata = {16'h0, st_ff.upper};
            lower_limit_off: nxt_st.rdata = {16'h0, st_ff.lower};
            out_sel_off: nxt_st.rdata = {8'h0, st_ff.out_sel};
            in_sel_off: nxt_st.rdata = st_ff.in_sel[31:0];
            main_speed_off: nxt_st.rdata = {st_ff.gain_hz, st_ff.bias_hz};
            accel_off: nxt_st.rdata = {st_ff.decel_step, st_ff.accel_step};
            status_off: nxt_st.rdata = {8'h0, st_ff.in_sel[55:32]};
            cmd_off: nxt_st.rdata = {st_ff.meas, st_ff.cmd};
            pid_out_off: nxt_st.rdata = {10'h0, st_ff.fwd_flag, st_ff.act_flag, st_ff.dn_flag, st_ff.up_flag,
                                         st_ff.pid_out};
            default: nxt_st.rdata = 32'h0;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // [R16] ramp uses only the second times; primary times are outside this block
   assign rif.target = st_ff.main_hold;
   assign rif.accel_step = st_ff.accel_step;
   assign rif.decel_step = st_ff.decel_step;
   assign rif.tick = st_ff.tick;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff <= '0;
         st_ff.set_point <= no_function;
         st_ff.upper <= no_function;
         st_ff.lower <= no_function;
         st_ff.diff_time <= diff_min;
         st_ff.gain_hz <= 16'h1388;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end
   assign prdata = st_ff.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign speed_cmd = st_ff.cmd;
   assign output_terms = st_ff.terms;
   assign output_common = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   a_upper_flag: assert property (@(posedge clk) disable iff (!reset_n)
      st_ff.up_flag |-> (st_ff.upper != no_function)) else $error("upper flag with limit off"); // [R11]
   a_lower_flag: assert property (@(posedge clk) disable iff (!reset_n)
      st_ff.dn_flag |-> (st_ff.lower != no_function)) else $error("lower flag with limit off"); // [R12]
   a_active_range: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && st_ff.tick) |=> (st_ff.act_flag == $past(active))) else $error("active flag wrong"); // [R1]
   a_idle_pid: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && st_ff.tick && !active) |=> st_ff.pid_out == 18'sd0) else $error("pid not cleared"); // [R9]
   a_fwd_flag: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
      (clk_en && st_ff.tick) |=> st_ff.fwd_flag == ($past(rot_forward) && !$past(rot_reverse)))
      else $error("forward flag wrong");
   a_sample_tick: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && st_ff.tick) |=> !st_ff.tick) else $error("tick too long"); // [R19]
   a_sp_default: assert property (@(posedge clk) disable iff (!reset_n)
      (st_ff.set_point == no_function) |-> sp_eff == pct_half) else $error("set point default wrong"); // [R3]
   a_pid_bound: assert property (@(posedge clk) disable iff (!reset_n)
      st_ff.pid_out <= $signed({2'b00, pct_full})) else $error("pid above full"); // [R2]
   a_pid_floor: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
      st_ff.pid_out >= -$signed({2'b00, pct_full})) else $error("pid below full");
   ////////////////////////////////////////////////////////////////////////////
   // multi-step checks: a sample tick, a set point write or any enabled cycle, then the registered result one cycle later; a_diff_range holds every cycle
   sequence s_live_tick;
      clk_en && st_ff.tick && active;
   endsequence
   sequence s_idle_tick;
      clk_en && st_ff.tick && !active;
   endsequence
   sequence s_sp_bad_write;
      clk_en && wr && paddr == set_point_off && pwdata[15:0] > pct_full && pwdata[15:0] != no_function;
   endsequence
   a_pid_update: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
      s_live_tick |=> st_ff.pid_out == $past(pid_raw)) else $error("pid output not taken on tick");
   a_cmd_idle: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
      s_idle_tick |=> st_ff.cmd == $past(rif.speed)) else $error("idle command not main speed");
   a_sp_refused: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
      s_sp_bad_write |=> $stable(st_ff.set_point)) else $error("bad set point accepted");
   a_diff_range: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
      st_ff.diff_time >= diff_min && st_ff.diff_time <= diff_max) else $error("derivative time out of range");
   a_main_hold: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
      clk_en |=> st_ff.main_hold == ($past(main_from_feedback) ? $past(st_ff.main_hold) : $past(main_speed_in)))
      else $error("main source from feedback taken");
endmodule : dancer_pid_speed_trim

/* sim/dancer_sensor_model.sv */
// Purpose: roller position sensor and main speed source beside the dancer block
// Assumes: adc samples follow the commanded roller position one clock later
// Notes: main source never comes from the feedback terminal here
`timescale 1ns/1ns
module dancer_sensor_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [11:0] position,
   output logic [11:0] feedback_raw,
   output logic [15:0] main_speed_in,
   output logic main_from_feedback,
   output logic rot_forward,
   output logic rot_reverse
);
   ////////////////////////////////////////////////////////////////////////////////
   // a real adc lags the roller, so the sample is registered
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         feedback_raw <= 12'h000;
         main_speed_in <= 16'h0000;
         main_from_feedback <= 1'b0;
         rot_forward <= 1'b0;
         rot_reverse <= 1'b0;
      end else begin
         feedback_raw <= position;
         main_speed_in <= 16'h1388;
         main_from_feedback <= 1'b0;
         rot_forward <= 1'b1;
         rot_reverse <= 1'b0;
      end
   end
endmodule : dancer_sensor_model

/* sim/dancer_pid_speed_trim_test.sv */
// Purpose: self-checking bench for the dancer speed trim block
// Assumes: zero wait APB slave, three sample ticks within the run
// Notes: three sample periods fit in the run, so the flag checks share them
`timescale 1ns/1ns
module dancer_pid_speed_trim_test;
   import dancer_pkg::*;
   typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp_v;} row_t;
   localparam int n_rows = 12;
   logic clk, clk_en, reset_n, psel, penable, pwrite, pready, pslverr, output_common;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] input_terms;
   logic [11:0] position, feedback_raw;
   logic [15:0] main_speed_in, speed_cmd;
   logic main_from_feedback, rot_forward, rot_reverse;
   logic [n_terms-1:0] output_terms;
   int failures, check_count;
   row_t rows [n_rows] = '{
      '{1'b0, set_point_off, 32'h0000_0000, 32'h0000_270f},
      '{1'b0, diff_time_off, 32'h0000_0000, 32'h0000_0001},
      '{1'b0, upper_limit_off, 32'h0000_0000, 32'h0000_270f},
      '{1'b0, lower_limit_off, 32'h0000_0000, 32'h0000_270f},
      '{1'b1, set_point_off, 32'h0000_03e8, 32'h0000_03e8},
      '{1'b1, set_point_off, 32'h0000_03e9, 32'h0000_03e8},
      '{1'b1, set_point_off, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, set_point_off, 32'h0000_270f, 32'h0000_270f},
      '{1'b1, diff_time_off, 32'h0000_0000, 32'h0000_0001},
      '{1'b1, diff_time_off, 32'h0001_03e8, 32'h0001_03e8},
      '{1'b1, diff_time_off, 32'h0000_03e9, 32'h0000_03e8},
      '{1'b1, 8'h3c, 32'hffff_ffff, 32'h0000_0000}
   };
   ////////////////////////////////////////////////////////////////////////////////
   dancer_pid_speed_trim dancer_pid_speed_trim_i (
      .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_terms(input_terms), .feedback_raw(feedback_raw), .main_speed_in(main_speed_in),
      .main_from_feedback(main_from_feedback), .rot_forward(rot_forward), .rot_reverse(rot_reverse),
      .speed_cmd(speed_cmd), .output_terms(output_terms), .output_common(output_common)
   );
   dancer_sensor_model dancer_sensor_model_i (
      .clk(clk), .reset_n(reset_n), .position(position), .feedback_raw(feedback_raw),
      .main_speed_in(main_speed_in), .main_from_feedback(main_from_feedback),
      .rot_forward(rot_forward), .rot_reverse(rot_reverse)
   );
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
      check_count++;
      if (seen !== exp_v) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp_v);
      end
   endtask : check
   task automatic end_of_test();
      if (failures == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   // holds the request until pready is seen high, so wait states would also work
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      if (n >= 50) begin
         failures++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4 * sample_cycles) @(posedge clk);
      failures++;
      end_of_test();
   end
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      input_terms = 7'h55;
      position = 12'hfff;
      failures = 0;
      check_count = 0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      // input_terms sit at 7'h55 but no terminal is mapped to pid select, so they must not matter
      for (int i = 0; i < n_rows; i++) begin
         if (rows[i].wr) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
         end
         apb(1'b0, rows[i].addr, 32'h0000_0000);
         check(rd, rows[i].exp_v);
      end
      // action 41, 0..10 v range; upper 80%, lower off; terms: upper, lower negative, pid active
      apb(1'b1, upper_limit_off, 32'h0000_0320);
      apb(1'b1, out_sel_off, 32'h002f_720f);
      apb(1'b1, in_sel_off, 32'h0000_0000);
      apb(1'b1, accel_off, 32'h0000_0000);
      apb(1'b1, ctrl_off, 32'h0000_0229);
      apb(1'b0, ctrl_off, 32'h0000_0000);
      check(rd, 32'h0000_0229);
      input_terms <= 7'h2a;
      // pid output and command each take one tick, so two ticks pass first
      repeat (2 * sample_cycles + 100) @(posedge clk);
      check({29'h0, output_terms}, 32'h0000_0007);
      check({31'h0, output_common}, 32'h0000_0000);
      check({31'h0, (speed_cmd !== 16'h0000) && (speed_cmd !== 16'h1388)}, 32'h0000_0001);
      // terminal 0 now carries pid select and is low; 0..5 v range near half scale
      position <= 12'h3ff;
      apb(1'b1, in_sel_off, 32'h0000_000e);
      apb(1'b1, ctrl_off, 32'h0000_0129);
      repeat (sample_cycles + 100) @(posedge clk);
      check({16'h0, speed_cmd}, 32'h0000_1388);
      check({29'h0, output_terms}, 32'h0000_0002);
      apb(1'b0, cmd_off, 32'h0000_0000);
      check(rd, 32'h01f3_1388);
      apb(1'b0, pid_out_off, 32'h0000_0000);
      check(rd, 32'h0020_0000);
      // a frozen clock enable must swallow the write
      clk_en <= 1'b0;
      apb(1'b1, set_point_off, 32'h0000_0064);
      clk_en <= 1'b1;
      apb(1'b0, set_point_off, 32'h0000_0000);
      check(rd, 32'h0000_270f);
      end_of_test();
   end
endmodule : dancer_pid_speed_trim_test
